// [logic/apc_regs.svh]
// register offsets, field positions, reset values and timing figures
`ifndef APC_REGS_SVH
`define APC_REGS_SVH
`define APC_SER_ADDR 8'h1B
`define APC_ANG_ADDR 8'h1C
`define APC_LPC_ADDR 8'h1D
`define APC_COM_ADDR 8'h1E
`define APC_SER_RST 24'h000000
`define APC_ANG_RST 24'h028000
`define APC_LPC_RST 24'h80B29F
`define APC_COM_RST 24'h0C094D
`define APC_SER_MASK 24'h00000B
`define APC_LPC_MASK 24'hB3F7FF
`define APC_COM_MASK 24'hFC3FFF
`define APC_SER_DM 3
`define APC_SER_S17 1
`define APC_SER_SC 0
`define APC_ANG_EXP 23:20
`define APC_ANG_FLIP 19
`define APC_ANG_DIR 18
`define APC_ANG_HYS 17:12
`define APC_ANG_ZERO 11:0
`define APC_LPC_T45 23
`define APC_LPC_SHIP 21
`define APC_LPC_SLEEP_CYCLING_BLOCK 20
`define APC_LPC_CYC 17:12
`define APC_LPC_WAKE 10:0
`define APC_COM_LOCK 23:20
`define APC_COM_LBE 19
`define APC_COM_CSE 18
`define APC_COM_DST 13
`define APC_COM_DHR 12
`define APC_COM_HI 11:6
`define APC_COM_LO 5:0
`define APC_LOCK_NVM 4'hC
`define APC_LOCK_ALL 4'h3
`define APC_EXP_MAX 4'hC
`define APC_HALF_TURN 14'h2000
`define APC_CLK_MHZ 40
`define APC_ST_TIME_US 30000
`define APC_SLEEP_UNIT_US 8192
`endif

// [logic/apc_pkg.sv]
// types of the angle post-processing and low-power configuration block
package apc_pkg;
    typedef enum logic [1:0] {LP_NORMAL, LP_SLEEP, LP_WAKE} apc_lp_t;
    typedef struct packed {
        logic [23:0] ser;
        logic [23:0] angle_processing_config;
        logic [23:0] low_power_config;
        logic [23:0] lock_selftest_field_config;
    } apc_regs_t;
    typedef struct packed {
        apc_regs_t r;
        logic [23:0] rdata;
        logic [25:0] acc;
        logic [12:0] cnt;
        logic [13:0] angle;
        logic angle_valid;
        logic [15:0] turns;
        apc_lp_t lp;
        logic [25:0] lp_timer;
        logic [11:0] ref_angle;
        logic [15:0] alive;
        logic ship_armed;
        logic ship;
        logic started;
        logic st_logic;
        logic st_hall;
        logic [20:0] st_timer;
        logic hard_reset;
        logic manch_ok;
        logic pkt_ok;
        logic field_high;
        logic field_low;
        logic sleeping;
        logic nvm_en;
        logic shadow_en;
    } apc_state_t;
endpackage

// [logic/apc_top.sv]
// angle post-processing, low-power cycling, lock and self-test configuration
`timescale 1ns/1ps
`default_nettype none
`include "apc_regs.svh"
// What this block does
// R01 - manchester_disable set: every supply-line Manchester command is ignored
// R02 - extra_clock_ignore set: a 17th SPI clock in a frame is ignored
// R03 - crc_check_bypass clear: bad-CRC packets are dropped; set: no check
// R04 - average 2^average_exponent samples, exponent capped at 12
// R05 - output updates every sample, interval doubling per exponent step
// R06 - host keeps average_exponent zero unless response time is unimportant
// R07 - half_turn_flip adds 180 degrees after direction, before hysteresis
// R08 - spin_sense_select picks clockwise or counter-clockwise, after offset
// R09 - 6-bit hysteresis in 14-bit angle units, zero disables
// R10 - 12-bit zero_shift subtracted before direction and flip
// R11 - turns counter steps 180 degrees or 45 degrees by turn_step_select
// R12 - ship command arms shipping mode at next sleep entry from LP_NORMAL unless blocked
// R13 - sleep_cycling_block set: sleep-cycling state never entered
// R14 - sleep interval is (N+1) x 8.192 ms, also alive counter rate
// R15 - angle change per interval vs wake_motion_limit steers sleep and wake
// R16 - wake_motion_limit is 11 bits of 360/4096 degrees, kept below 180
// R17 - lock 1100 blocks nonvolatile writes, 0011 also blocks shadow writes
// R18 - powerup_logic_selftest runs the scan logic self-test at power-up
// R19 - powerup_hall_selftest runs the transducer self-test at power-up
// R20 - both power-up self-tests run together within one 30 ms window
// R21 - selftest_cmd_block refuses self-test start by command
// R22 - hard_reset_cmd_block refuses hard reset by command
// R23 - strong_field_limit in 32 G steps, zero disables the check
// R24 - weak_field_limit in 16 G steps, zero disables the check
// R25 - other lock values leave both memories writable
// R26 - pipeline order: average, offset, direction, flip, hysteresis
module apc_top #(
    parameter int ST_CYCLES = `APC_ST_TIME_US * `APC_CLK_MHZ,
    parameter int SLEEP_UNIT_CYCLES = `APC_SLEEP_UNIT_US * `APC_CLK_MHZ
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [23:0] i_reg_wdata,
    input wire logic i_sample_valid,
    input wire logic [13:0] i_sample,
    input wire logic i_manch_cmd,
    input wire logic i_pkt_valid,
    input wire logic i_pkt_crc_ok,
    input wire logic i_ship_cmd,
    input wire logic i_selftest_cmd,
    input wire logic i_hard_reset_cmd,
    input wire logic [7:0] i_field_mag,
    output logic [23:0] o_reg_rdata,
    output logic [13:0] o_angle,
    output logic o_angle_valid,
    output logic [15:0] o_turns,
    output logic [15:0] o_alive,
    output logic o_sleeping,
    output logic o_ship_mode,
    output logic o_manch_cmd_ok,
    output logic o_pkt_accept,
    output logic o_spi_ignore_17th,
    output logic o_nvm_wr_en,
    output logic o_shadow_wr_en,
    output logic o_logic_selftest,
    output logic o_hall_selftest,
    output logic o_hard_reset,
    output logic o_field_high,
    output logic o_field_low
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ------------------------------------------------------------
    // state and next state
    // ------------------------------------------------------------
    apc_pkg::apc_state_t s;
    apc_pkg::apc_state_t next_s;
    logic [3:0] exp_eff;
    logic [12:0] cnt_inc;
    logic [25:0] acc_sum;
    logic [13:0] avg;
    logic [13:0] proc;
    logic [13:0] hdiff;
    logic [13:0] hmag;
    logic [2:0] sec_old;
    logic [2:0] sec_new;
    logic [11:0] ldiff;
    logic [11:0] lmag;
    logic lp_still;
    logic [25:0] lp_period;
    logic [3:0] lock;
    logic shadow_ok;

    always_comb begin
        next_s = s;
        next_s.angle_valid = 1'b0;
        next_s.hard_reset = 1'b0;
        next_s.manch_ok = i_manch_cmd && !s.r.ser[`APC_SER_DM]; // see R01
        next_s.pkt_ok = i_pkt_valid && (i_pkt_crc_ok || s.r.ser[`APC_SER_SC]); // see R03
        lock = s.r.lock_selftest_field_config[`APC_COM_LOCK];
        shadow_ok = (lock != `APC_LOCK_ALL); // see R17 R25
        // register port; lock field is permanent once a lock code is held
        if (i_reg_wr && shadow_ok) begin
            unique case (i_reg_addr)
                `APC_SER_ADDR: next_s.r.ser = i_reg_wdata & `APC_SER_MASK;
                `APC_ANG_ADDR: next_s.r.angle_processing_config = i_reg_wdata;
                `APC_LPC_ADDR: next_s.r.low_power_config = i_reg_wdata & `APC_LPC_MASK;
                `APC_COM_ADDR: begin
                    next_s.r.lock_selftest_field_config = i_reg_wdata & `APC_COM_MASK;
                    if (lock == `APC_LOCK_NVM) begin
                        next_s.r.lock_selftest_field_config[`APC_COM_LOCK] = lock;
                    end
                end
                default: next_s.r = s.r;
            endcase
        end
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `APC_SER_ADDR: next_s.rdata = s.r.ser;
                `APC_ANG_ADDR: next_s.rdata = s.r.angle_processing_config;
                `APC_LPC_ADDR: next_s.rdata = s.r.low_power_config;
                `APC_COM_ADDR: next_s.rdata = s.r.lock_selftest_field_config;
                default: next_s.rdata = 24'h000000;
            endcase
        end
        // averaging, then offset, direction, flip, hysteresis
        exp_eff = (s.r.angle_processing_config[`APC_ANG_EXP] > `APC_EXP_MAX) ? `APC_EXP_MAX : s.r.angle_processing_config[`APC_ANG_EXP]; // see R04
        cnt_inc = s.cnt + 13'h0001;
        acc_sum = s.acc + {12'h000, i_sample};
        avg = 14'(acc_sum >> exp_eff);
        proc = avg - {s.r.angle_processing_config[`APC_ANG_ZERO], 2'h0}; // see R10 R26
        if (s.r.angle_processing_config[`APC_ANG_DIR]) begin
            proc = 14'h0000 - proc; // see R08
        end
        if (s.r.angle_processing_config[`APC_ANG_FLIP]) begin
            proc = proc + `APC_HALF_TURN; // see R07
        end
        hdiff = proc - s.angle;
        hmag = hdiff[13] ? 14'h0000 - hdiff : hdiff;
        sec_old = s.angle[13:11];
        sec_new = proc[13:11];
        if (i_sample_valid) begin
            next_s.acc = acc_sum;
            next_s.cnt = cnt_inc;
            if (cnt_inc == (13'h0001 << exp_eff)) begin // see R05
                next_s.acc = 26'h0000000;
                next_s.cnt = 13'h0000;
                next_s.angle_valid = 1'b1;
                if (hmag > {8'h00, s.r.angle_processing_config[`APC_ANG_HYS]}) begin // see R09
                    next_s.angle = proc;
                    // small steps inside the band never reach the turns counter
                    if (sec_new == sec_old + 3'h1 && (s.r.low_power_config[`APC_LPC_T45] || sec_new[1:0] == 2'h0)) begin
                        next_s.turns = s.turns + 16'h0001; // see R11
                    end else if (sec_new == sec_old - 3'h1
                                 && (s.r.low_power_config[`APC_LPC_T45] || sec_old[1:0] == 2'h0)) begin
                        next_s.turns = s.turns - 16'h0001; // see R11
                    end
                end
            end
        end
        // low-power cycling
        lp_period = 26'(({20'h00000, s.r.low_power_config[`APC_LPC_CYC]} + 26'h0000001) * 26'(SLEEP_UNIT_CYCLES)); // see R14
        ldiff = s.angle[13:2] - s.ref_angle;
        lmag = ldiff[11] ? 12'h000 - ldiff : ldiff;
        lp_still = lmag < {1'b0, s.r.low_power_config[`APC_LPC_WAKE]}; // see R15 R16
        if (i_ship_cmd && !s.r.low_power_config[`APC_LPC_SHIP]) begin
            next_s.ship_armed = 1'b1; // see R12
        end
        next_s.lp_timer = s.lp_timer + 26'h0000001;
        if (s.lp_timer >= lp_period - 26'h0000001) begin
            next_s.lp_timer = 26'h0000000;
            next_s.alive = s.alive + 16'h0001; // see R14
            next_s.ref_angle = s.angle[13:2];
            unique case (s.lp)
                apc_pkg::LP_NORMAL: begin
                    if (lp_still && !s.r.low_power_config[`APC_LPC_SLEEP_CYCLING_BLOCK]) begin // see R13 R15
                        next_s.lp = apc_pkg::LP_SLEEP;
                        if (s.ship_armed && !s.r.low_power_config[`APC_LPC_SHIP]) begin
                            next_s.ship = 1'b1; // see R12
                        end
                    end
                end
                apc_pkg::LP_SLEEP: next_s.lp = apc_pkg::LP_WAKE;
                apc_pkg::LP_WAKE: next_s.lp = lp_still ? apc_pkg::LP_SLEEP : apc_pkg::LP_NORMAL; // see R15
            endcase
        end
        if (s.r.low_power_config[`APC_LPC_SLEEP_CYCLING_BLOCK]) begin
            next_s.lp = apc_pkg::LP_NORMAL; // see R13
        end
        // self-tests share one timer so the ones that run always end together
        if (!s.started) begin
            next_s.started = 1'b1;
            next_s.st_logic = s.r.lock_selftest_field_config[`APC_COM_LBE]; // see R18 R20
            next_s.st_hall = s.r.lock_selftest_field_config[`APC_COM_CSE]; // see R19 R20
            next_s.st_timer = 21'h000000;
        end else if (s.st_logic || s.st_hall) begin
            next_s.st_timer = s.st_timer + 21'h000001;
            if (s.st_timer == 21'(ST_CYCLES - 1)) begin
                next_s.st_logic = 1'b0;
                next_s.st_hall = 1'b0;
            end
        end else if (i_selftest_cmd && !s.r.lock_selftest_field_config[`APC_COM_DST]) begin // see R21
            next_s.st_logic = 1'b1;
            next_s.st_hall = 1'b1;
            next_s.st_timer = 21'h000000;
        end
        next_s.hard_reset = i_hard_reset_cmd && !s.r.lock_selftest_field_config[`APC_COM_DHR]; // see R22
        next_s.field_high = (s.r.lock_selftest_field_config[`APC_COM_HI] != 6'h00)
                            && (i_field_mag > {1'b0, s.r.lock_selftest_field_config[`APC_COM_HI], 1'b0}); // see R23
        next_s.field_low = (s.r.lock_selftest_field_config[`APC_COM_LO] != 6'h00)
                           && (i_field_mag < {2'h0, s.r.lock_selftest_field_config[`APC_COM_LO]}); // see R24
        // decoded flags get their own flops so no output pin sees decode glitches
        next_s.sleeping = (next_s.lp == apc_pkg::LP_SLEEP);
        next_s.nvm_en = (next_s.r.lock_selftest_field_config[`APC_COM_LOCK] != `APC_LOCK_NVM)
                        && (next_s.r.lock_selftest_field_config[`APC_COM_LOCK] != `APC_LOCK_ALL); // see R17 R25
        next_s.shadow_en = (next_s.r.lock_selftest_field_config[`APC_COM_LOCK] != `APC_LOCK_ALL); // see R17 R25
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.r.ser <= `APC_SER_RST;
            s.r.angle_processing_config <= `APC_ANG_RST;
            s.r.low_power_config <= `APC_LPC_RST;
            s.r.lock_selftest_field_config <= `APC_COM_RST;
            s.lp <= apc_pkg::LP_NORMAL;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_reg_rdata = s.rdata;
    assign o_angle = s.angle;
    assign o_angle_valid = s.angle_valid;
    assign o_turns = s.turns;
    assign o_alive = s.alive;
    assign o_sleeping = s.sleeping;
    assign o_ship_mode = s.ship;
    assign o_manch_cmd_ok = s.manch_ok;
    assign o_pkt_accept = s.pkt_ok;
    assign o_spi_ignore_17th = s.r.ser[`APC_SER_S17]; // see R02
    assign o_nvm_wr_en = s.nvm_en; // see R17 R25
    assign o_shadow_wr_en = s.shadow_en; // see R17 R25
    assign o_logic_selftest = s.st_logic;
    assign o_hall_selftest = s.st_hall;
    assign o_hard_reset = s.hard_reset;
    assign o_field_high = s.field_high;
    assign o_field_low = s.field_low;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n);
    sequence seq_st_start;
        !o_logic_selftest ##1 o_logic_selftest;
    endsequence
    sequence seq_nvm_locked;
        s.r.lock_selftest_field_config[`APC_COM_LOCK] == `APC_LOCK_NVM;
    endsequence
    a_manch_pass: assert property (i_manch_cmd && !s.r.ser[`APC_SER_DM] |=> o_manch_cmd_ok) // see R01
        else $error("manchester command lost while enabled");
    a_hr_pass: assert property (i_hard_reset_cmd && !s.r.lock_selftest_field_config[`APC_COM_DHR] |=> o_hard_reset) // see R22
        else $error("hard reset lost while allowed");
    a_lock_keep: assert property (seq_nvm_locked |=> seq_nvm_locked) // see R17
        else $error("nonvolatile lock code changed");
    a_nvm_block: assert property (seq_nvm_locked |=> !o_nvm_wr_en) // see R17
        else $error("nonvolatile write enabled while locked");
    a_shadow_block: assert property (s.r.lock_selftest_field_config[`APC_COM_LOCK] == `APC_LOCK_ALL |=> !o_shadow_wr_en) // see R17
        else $error("shadow write enabled while locked");
    a_manch_gate: assert property (i_manch_cmd && s.r.ser[`APC_SER_DM] |=> !o_manch_cmd_ok) // see R01
        else $error("manchester command taken while disabled");
    a_crc_drop: assert property (i_pkt_valid && !i_pkt_crc_ok && !s.r.ser[`APC_SER_SC] |=> !o_pkt_accept) // see R03
        else $error("bad crc packet accepted");
    a_crc_bypass: assert property (i_pkt_valid && s.r.ser[`APC_SER_SC] |=> o_pkt_accept) // see R03
        else $error("packet dropped with check bypassed");
    a_sleep_block: assert property ($rose(o_sleeping) |-> !$past(s.r.low_power_config[`APC_LPC_SLEEP_CYCLING_BLOCK])) // see R13
        else $error("sleep entered while blocked");
    a_ship_block: assert property ($rose(o_ship_mode) |-> !$past(s.r.low_power_config[`APC_LPC_SHIP]) && $past(s.ship_armed)) // see R12
        else $error("ship mode entered without arming");
    a_lock_all: assert property (s.r.lock_selftest_field_config[`APC_COM_LOCK] == `APC_LOCK_ALL |=> $stable(s.r)) // see R17
        else $error("shadow written while locked");
    a_st_refuse: assert property (i_selftest_cmd && s.r.lock_selftest_field_config[`APC_COM_DST] && s.started |=> !$rose(o_logic_selftest)) // see R21
        else $error("self-test started while blocked");
    a_st_pair: assert property (seq_st_start |-> o_hall_selftest [*8]) // see R20
        else $error("self-tests not run together");
    a_hr_block: assert property (i_hard_reset_cmd && s.r.lock_selftest_field_config[`APC_COM_DHR] |=> !o_hard_reset) // see R22
        else $error("hard reset taken while blocked");
    a_field_off: assert property (s.r.lock_selftest_field_config[`APC_COM_HI] == 6'h00 |=> !o_field_high) // see R23
        else $error("high field flag with check disabled");
endmodule
`default_nettype wire

// [verif/apc_host.sv]
// host model driving the register port of the configuration block
`timescale 1ns/1ps
`default_nettype none
module apc_host (
    input wire logic i_clock,
    input wire logic [23:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [23:0] o_wdata
);
    // wake limits stay far below half a turn
    // nonzero exponents only where averaging itself is exercised
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 24'h000000;
    end
    task automatic wr(input logic [7:0] a, input logic [23:0] dv);
        @(posedge i_clock);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= dv;
        @(posedge i_clock);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~dv;
    endtask
    // data is picked up a full cycle later, it stands until the next read
    task automatic rd(input logic [7:0] a, output logic [23:0] dv);
        @(posedge i_clock);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clock);
        o_rd <= 1'b0;
        o_addr <= ~a;
        @(posedge i_clock);
        #1 dv = i_rdata;
    endtask
endmodule
`default_nettype wire

// [verif/apc_top_test.sv]
// self-checking bench for the angle post-processing configuration block
`timescale 1ns/1ps
`default_nettype none
`include "apc_regs.svh"
module apc_top_test;
    localparam int ST = 20;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic wr, rd, av, slp, shp, mok, pok, s17, nvm, shd, lst, hst, hrs, fh, fl;
    logic sv = 1'b0;
    logic crc = 1'b0;
    logic [4:0] cmd = 5'h00;
    logic [7:0] addr;
    logic [7:0] mag = 8'h00;
    logic [13:0] smp = 14'h0000;
    logic [13:0] angle_processing_config, e;
    logic [15:0] turns, alive, a0;
    logic [23:0] wdata, rdata, d, cf;
    logic [23:0] rv [4] = '{`APC_SER_RST, `APC_ANG_RST, `APC_LPC_RST, `APC_COM_RST};
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int f;
    always #12.5 clk = ~clk;
    apc_host host_u (.i_clock(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    apc_top #(.ST_CYCLES(ST), .SLEEP_UNIT_CYCLES(16)) dut_u (
        .i_clock(clk), .i_arst_n(arst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_sample_valid(sv), .i_sample(smp), .i_manch_cmd(cmd[0]),
        .i_pkt_valid(cmd[1]), .i_pkt_crc_ok(crc), .i_ship_cmd(cmd[2]), .i_selftest_cmd(cmd[3]),
        .i_hard_reset_cmd(cmd[4]), .i_field_mag(mag), .o_reg_rdata(rdata), .o_angle(angle_processing_config),
        .o_angle_valid(av), .o_turns(turns), .o_alive(alive), .o_sleeping(slp), .o_ship_mode(shp),
        .o_manch_cmd_ok(mok), .o_pkt_accept(pok), .o_spi_ignore_17th(s17), .o_nvm_wr_en(nvm),
        .o_shadow_wr_en(shd), .o_logic_selftest(lst), .o_hall_selftest(hst), .o_hard_reset(hrs),
        .o_field_high(fh), .o_field_low(fl));
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // the whole run needs well under 20000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic kick(input int b);
        @(posedge clk);
        cmd <= 5'h01 << b;
        @(posedge clk);
        cmd <= 5'h00;
        #1;
    endtask
    task automatic feed(input int n, input logic [13:0] v, output int first);
        first = 0;
        for (int i = 1; i <= n + 1; i++) begin
            @(posedge clk);
            sv <= (i <= n);
            smp <= v;
            #1;
            if (av === 1'b1 && first == 0) first = i - 1;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_defaults();
        do_reset();
        chk("pwrup tests", {lst, hst}, 2'b11);
        chk("unlocked", {nvm, shd}, 2'b11);
        for (int i = 0; i < 4; i++) begin
            host_u.rd(8'h1B + 8'(i), d);
            chk("reset value", d, rv[i]);
        end
        host_u.rd(8'h1F, d);
        chk("unmapped", d, 24'h000000);
        repeat (ST) @(posedge clk);
        #1 chk("pwrup end", {lst, hst}, 2'b00);
        host_u.wr(`APC_LPC_ADDR, `APC_LPC_RST | 24'h100000);
        $display("test defaults done");
    endtask
    task automatic t_serial();
        host_u.wr(`APC_SER_ADDR, 24'h000000);
        settle();
        chk("s17 off", s17, 1'b0);
        kick(0);
        chk("manch on", mok, 1'b1);
        kick(1);
        chk("bad crc", pok, 1'b0);
        @(posedge clk);
        crc <= 1'b1;
        kick(1);
        chk("good crc", pok, 1'b1);
        @(posedge clk);
        crc <= 1'b0;
        host_u.wr(`APC_SER_ADDR, 24'h00000B);
        settle();
        chk("s17 on", s17, 1'b1);
        kick(0);
        chk("manch off", mok, 1'b0);
        kick(1);
        chk("bypass", pok, 1'b1);
        $display("test serial done");
    endtask
    task automatic t_cmds();
        kick(4);
        chk("hard rst", hrs, 1'b1);
        kick(3);
        chk("st cmd", {lst, hst}, 2'b11);
        repeat (ST + 4) @(posedge clk);
        host_u.wr(`APC_COM_ADDR, 24'h0C394D);
        kick(3);
        chk("st refused", {lst, hst}, 2'b00);
        kick(4);
        chk("rst refused", hrs, 1'b0);
        $display("test commands done");
    endtask
    task automatic t_field();
        logic [7:0] mv [4] = '{8'h4B, 8'h4A, 8'h0D, 8'h0C};
        logic [1:0] ev [4] = '{2'b10, 2'b00, 2'b00, 2'b01};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            mag <= mv[i];
            settle();
            chk("field flags", {fh, fl}, ev[i]);
        end
        host_u.wr(`APC_COM_ADDR, 24'h0C0000);
        mag <= 8'hFF;
        settle();
        chk("hi off", fh, 1'b0);
        @(posedge clk);
        mag <= 8'h00;
        settle();
        chk("lo off", fl, 1'b0);
        $display("test field done");
    endtask
    task automatic t_angle();
        logic [23:0] cv [4] = '{24'h000000, 24'h000010, 24'h040010, 24'h0C0010};
        for (int i = 0; i < 4; i++) begin
            cf = cv[i];
            host_u.wr(`APC_ANG_ADDR, cf);
            e = 14'h1234 - {cf[11:0], 2'b00};
            if (cf[18]) e = -e;
            if (cf[19]) e = e + `APC_HALF_TURN;
            feed(1, 14'h1234, f);
            chk("rate 1", f, 1);
            chk("angle", angle_processing_config, e);
        end
        host_u.wr(`APC_ANG_ADDR, 24'h004000);
        feed(1, 14'h2000, f);
        feed(1, 14'h2004, f);
        chk("hys hold", angle_processing_config, 14'h2000);
        feed(1, 14'h2005, f);
        chk("hys move", angle_processing_config, 14'h2005);
        host_u.wr(`APC_ANG_ADDR, 24'h200000);
        feed(4, 14'h0100, f);
        chk("avg 4", f, 4);
        chk("avg val", angle_processing_config, 14'h0100);
        host_u.wr(`APC_ANG_ADDR, 24'hF00000);
        feed(4096, 14'h0300, f);
        chk("avg cap", f, 4096);
        chk("cap val", angle_processing_config, 14'h0300);
        host_u.wr(`APC_ANG_ADDR, 24'h000000);
        $display("test angle done");
    endtask
    task automatic t_turns();
        for (int m = 0; m < 2; m++) begin
            host_u.wr(`APC_LPC_ADDR, {m[0], 23'h10029F});
            feed(1, 14'h0000, f);
            a0 = turns;
            for (int k = 1; k <= 8; k++) feed(1, 14'(k * 14'h0800), f);
            chk("turns", turns - a0, m ? 16'h0008 : 16'h0002);
        end
        $display("test turns done");
    endtask
    task automatic t_sleep();
        for (int t = 0; t < 2; t++) begin
            do_reset();
            host_u.wr(`APC_LPC_ADDR, t ? 24'h90029F : 24'hB0029F);
            repeat (40) @(posedge clk);
            #1 a0 = alive;
            f = 0;
            repeat (160) begin
                @(posedge clk);
                #1 f += (slp !== 1'b0);
            end
            chk("alive", alive - a0, 16'h000A);
            chk("blocked", f, 0);
            kick(2);
            host_u.wr(`APC_LPC_ADDR, t ? 24'h80029F : 24'hA0029F);
            f = 0;
            repeat (64) begin
                @(posedge clk);
                #1 f += (slp === 1'b1);
            end
            chk("sleeps", f > 0, 1'b1);
            chk("ship", shp, t[0]);
        end
        $display("test sleep done");
    endtask
    task automatic t_lock();
        host_u.wr(`APC_COM_ADDR, 24'h5C094D);
        settle();
        chk("other code", {nvm, shd}, 2'b11);
        host_u.wr(`APC_COM_ADDR, 24'hCC094D);
        settle();
        chk("nvm lock", {nvm, shd}, 2'b01);
        host_u.wr(`APC_COM_ADDR, 24'h3C094D);
        host_u.rd(`APC_COM_ADDR, d);
        chk("lock kept", d, 24'hCC094D);
        do_reset();
        host_u.wr(`APC_COM_ADDR, 24'h3C094D);
        settle();
        chk("all lock", {nvm, shd}, 2'b00);
        host_u.wr(`APC_ANG_ADDR, 24'h000123);
        host_u.rd(`APC_ANG_ADDR, d);
        chk("shadow kept", d, `APC_ANG_RST);
        $display("test lock done");
    endtask
    initial begin
        t_defaults();
        t_serial();
        t_cmds();
        t_field();
        t_angle();
        t_turns();
        t_sleep();
        t_lock();
        test_done();
    end
endmodule
`default_nettype wire
